// ### inc/gfs_params.svh
`ifndef GFS_PARAMS_SVH
`define GFS_PARAMS_SVH

// clock rate
`define GFS_CLK_HZ 20000000
`define GFS_CLK_KHZ 20000

// correlator bank
`define GFS_NUM_CH 15
`define GFS_IF_KHZ 4092

// carrier-to-noise thresholds, dBc-Hz
`define GFS_CN0_ACQ 8'd38
`define GFS_CN0_TRK 8'd25
`define GFS_CN0_FADE 8'd18
`define GFS_CN0_NAV 8'd30

// elevation mask, degrees
`define GFS_ELEV_MASK 8'sd3

// satellites needed for a 3d solution
`define GFS_MIN_SATS 4

// times in ms
`define GFS_BLINK_HALF_MS 1000
`define GFS_EPOCH_MS 1000
`define GFS_PULSE_MS 100
`define GFS_FADE_MS 3000
`define GFS_SEEK_MS 2000

// report serial line, 8n1
`define GFS_BAUD 9600
`define GFS_RPT_START 8'h24
`define GFS_RPT_BYTES 2'd3
`define GFS_FRAME_BITS 4'd10

`endif

// ### inc/gfs_pkg.sv
package gfs_pkg;

  // one correlator channel measurement
  typedef struct packed {
    logic [7:0] cn0;
    logic signed [7:0] elev;
  } gfs_meas_s;

  // satellite offered by the search engine
  typedef struct packed {
    logic valid;
    logic [5:0] prn;
  } gfs_cand_s;

  // nav_solution status of the last period
  typedef struct packed {
    logic fix;
    logic uncertain;
    logic empty;
    logic [3:0] used;
  } gfs_nav_s;

  typedef enum {FIX_NONE, FIX_SEARCH, FIX_VALID} gfs_fix_e;

  typedef enum {TRK_FREE, TRK_SEEK, TRK_LOCK, TRK_FADE} gfs_trk_e;

endpackage

// ### src/gfs_chan_trk.sv
`timescale 1ns/100ps
`include "gfs_params.svh"

module gfs_chan_trk #(
  parameter int SEEK_CYC = `GFS_CLK_KHZ * `GFS_SEEK_MS,
  parameter int FADE_CYC = `GFS_CLK_KHZ * `GFS_FADE_MS
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // allocation
  input wire logic assign_in,
  input wire logic [5:0] prn_in,
  input wire gfs_pkg::gfs_meas_s meas_in,
  // channel status
  output logic busy_out,
  output logic tracked_out,
  output logic nav_ok_out,
  output logic elev_ok_out,
  output logic [5:0] prn_out
);
  import gfs_pkg::*;

  localparam int TW = $clog2((SEEK_CYC > FADE_CYC ? SEEK_CYC : FADE_CYC) + 1);

  gfs_trk_e state_q;
  logic [TW-1:0] tmr_q;
  logic [5:0] prn_q;
  logic acq_lvl;
  logic keep_lvl;
  logic hold_lvl;

  // signal levels against the three thresholds
  assign acq_lvl = meas_in.cn0 >= `GFS_CN0_ACQ;
  assign keep_lvl = meas_in.cn0 > `GFS_CN0_TRK;
  assign hold_lvl = meas_in.cn0 >= `GFS_CN0_FADE;

  // channel tracking state and shared seek/fade timer
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      state_q <= TRK_FREE;
      tmr_q <= '0;
    end else begin
      case (state_q)
        TRK_FREE: begin
          tmr_q <= '0;
          if (assign_in) begin
            state_q <= TRK_SEEK;
          end
        end
        TRK_SEEK: begin
          if (acq_lvl) begin
            state_q <= TRK_LOCK;
          end else if (tmr_q == TW'(SEEK_CYC - 1)) begin
            state_q <= TRK_FREE; // give the channel back to the search
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        TRK_LOCK: begin
          tmr_q <= '0;
          if (!hold_lvl) begin
            state_q <= TRK_FREE;
          end else if (!keep_lvl) begin
            state_q <= TRK_FADE;
          end
        end
        TRK_FADE: begin
          if (!hold_lvl || tmr_q == TW'(FADE_CYC - 1)) begin
            state_q <= TRK_FREE;
          end else if (keep_lvl) begin
            state_q <= TRK_LOCK;
            tmr_q <= '0;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        default: begin
          state_q <= TRK_FREE;
          tmr_q <= '0;
        end
      endcase
    end
  end

  // satellite number held by this channel
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      prn_q <= '0;
    end else if (assign_in && state_q == TRK_FREE) begin
      prn_q <= prn_in;
    end
  end

  assign busy_out = state_q != TRK_FREE;
  assign tracked_out = state_q == TRK_LOCK || state_q == TRK_FADE;
  assign nav_ok_out = tracked_out && meas_in.cn0 >= `GFS_CN0_NAV;
  assign elev_ok_out = meas_in.elev >= `GFS_ELEV_MASK;
  assign prn_out = prn_q;

  property p_acq_level;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (state_q == TRK_SEEK) ##1 (state_q == TRK_LOCK) |-> $past(meas_in.cn0) >= `GFS_CN0_ACQ;
  endproperty
  a_acq_level: assert property (p_acq_level) else $error("lock without acquire level");

  property p_keep_lock;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (state_q == TRK_LOCK && keep_lvl) |=> (state_q == TRK_LOCK);
  endproperty
  a_keep_lock: assert property (p_keep_lock) else $error("lock lost above 25");

  property p_fade_hold;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (state_q == TRK_FADE && hold_lvl && tmr_q < TW'(FADE_CYC - 1)) |=> tracked_out;
  endproperty
  a_fade_hold: assert property (p_fade_hold) else $error("fade dropped early");

endmodule // gfs_chan_trk

// ### src/gfs_fix_status.sv
`timescale 1ns/100ps
`include "gfs_params.svh"

module gfs_fix_status #(
  parameter int NUM_CH = `GFS_NUM_CH,
  parameter int BLINK_CYC = `GFS_CLK_KHZ * `GFS_BLINK_HALF_MS,
  parameter int EPOCH_CYC = `GFS_CLK_KHZ * `GFS_EPOCH_MS,
  parameter int PULSE_CYC = `GFS_CLK_KHZ * `GFS_PULSE_MS,
  parameter int SEEK_CYC = `GFS_CLK_KHZ * `GFS_SEEK_MS,
  parameter int FADE_CYC = `GFS_CLK_KHZ * `GFS_FADE_MS,
  parameter int BAUD_DIV = `GFS_CLK_HZ / `GFS_BAUD
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // correlator measurements and search offers
  input wire gfs_pkg::gfs_meas_s meas_in [NUM_CH],
  input wire gfs_pkg::gfs_cand_s cand_in,
  input wire logic [7:0] precision_dilution_in,
  // serial pins
  input wire logic rxd_in,
  output logic tx_out,
  // status pins
  output logic fix_status_out,
  output logic pos_pulse_out,
  // nav_solution status and search handshake
  output gfs_pkg::gfs_nav_s nav_solution_out,
  output logic cand_ack_out
);
  import gfs_pkg::*;

  localparam int CW = $clog2(NUM_CH + 1);
  localparam int IW = $clog2(NUM_CH);
  localparam int BW = $clog2(BLINK_CYC);
  localparam int EW = $clog2(EPOCH_CYC);
  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam int DW = $clog2(BAUD_DIV);

  logic [NUM_CH-1:0] busy, tracked, nav_ok, elev_ok, dup, assign_q;
  logic [5:0] chan_prn [NUM_CH];
  logic [5:0] cand_prn_q;
  logic free_any;
  logic [IW-1:0] free_idx;
  logic [CW-1:0] trk_cnt, all_cnt, masked_cnt, used_d;
  logic issue_d, unc_d, gate_q, tick, ack_q;
  logic [EW-1:0] epoch_q;
  gfs_nav_s nav_q;
  gfs_fix_e fix_q, fix_d;
  logic [BW-1:0] blink_q;
  logic fix_out_q;
  logic [PW-1:0] pulse_q;
  logic pulse_out_q;
  logic [23:0] rpt_q;
  logic [9:0] shift_q;
  logic [3:0] bits_q;
  logic [1:0] bytes_q;
  logic [DW-1:0] baud_q;
  logic busy_tx_q, tx_q;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    gfs_chan_trk #(
      .SEEK_CYC(SEEK_CYC),
      .FADE_CYC(FADE_CYC)
    ) u_trk (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .assign_in(assign_q[g]),
      .prn_in(cand_prn_q),
      .meas_in(meas_in[g]),
      .busy_out(busy[g]),
      .tracked_out(tracked[g]),
      .nav_ok_out(nav_ok[g]),
      .elev_ok_out(elev_ok[g]),
      .prn_out(chan_prn[g])
    );
    assign dup[g] = busy[g] && (chan_prn[g] == cand_in.prn);
  end

  // receive pin unread
  // rxd_in feeds nothing, so no byte on it can reach any state

  // lowest free channel for the next offered satellite
  always_comb begin
    free_any = 1'b0;
    free_idx = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        free_any = 1'b1;
        free_idx = IW'(i);
      end
    end
  end

  // channel assignment
  // one offer per two cycles so the channel's busy flag settles first
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      assign_q <= '0;
      ack_q <= 1'b0;
      cand_prn_q <= '0;
    end else begin
      assign_q <= '0;
      ack_q <= 1'b0;
      if (cand_in.valid && assign_q == '0 && !ack_q) begin
        if (|dup) begin
          ack_q <= 1'b1; // already held, just consume the offer
        end else if (free_any) begin
          assign_q[free_idx] <= 1'b1;
          cand_prn_q <= cand_in.prn;
          ack_q <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    trk_cnt = '0;
    all_cnt = '0;
    masked_cnt = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      trk_cnt = trk_cnt + CW'(tracked[i]);
      all_cnt = all_cnt + CW'(nav_ok[i]);
      masked_cnt = masked_cnt + CW'(nav_ok[i] && elev_ok[i]);
    end
  end

  always_comb begin
    if (!gate_q) begin
      issue_d = all_cnt >= CW'(`GFS_MIN_SATS);
      unc_d = issue_d && masked_cnt < CW'(`GFS_MIN_SATS);
      used_d = all_cnt;
    end else begin
      issue_d = masked_cnt >= CW'(`GFS_MIN_SATS);
      unc_d = 1'b0;
      used_d = masked_cnt;
    end
  end

  assign tick = epoch_q == EW'(EPOCH_CYC - 1);
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      epoch_q <= '0;
    end else begin
      epoch_q <= tick ? '0 : epoch_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      gate_q <= 1'b0;
    end else if (tick && issue_d) begin
      gate_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      nav_q <= '0;
    end else if (tick) begin
      nav_q.fix <= issue_d;
      nav_q.uncertain <= unc_d;
      nav_q.empty <= !issue_d;
      nav_q.used <= 4'(used_d);
    end else if (trk_cnt == '0) begin
      nav_q.fix <= 1'b0; // losing every satellite ends the fix at once
    end
  end

  always_comb begin
    if (trk_cnt == '0) begin
      fix_d = FIX_NONE;
    end else if (nav_q.fix) begin
      fix_d = FIX_VALID;
    end else begin
      fix_d = FIX_SEARCH;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      fix_q <= FIX_NONE;
      blink_q <= '0;
    end else begin
      fix_q <= fix_d;
      if (fix_d != fix_q || blink_q == BW'(BLINK_CYC - 1)) begin
        blink_q <= '0;
      end else begin
        blink_q <= blink_q + 1'b1;
      end
    end
  end

  // blink half periods
  // search starts on the high half so a glance sees tracking promptly
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      fix_out_q <= 1'b0;
    end else if (fix_d != fix_q) begin
      fix_out_q <= fix_d != FIX_NONE;
    end else if (fix_q == FIX_SEARCH && blink_q == BW'(BLINK_CYC - 1)) begin
      fix_out_q <= !fix_out_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      pulse_q <= '0;
      pulse_out_q <= 1'b0;
    end else if (tick && issue_d) begin
      pulse_q <= PW'(PULSE_CYC - 1);
      pulse_out_q <= 1'b1;
    end else if (pulse_q != '0 && trk_cnt != '0) begin // total loss cuts the mark
      pulse_q <= pulse_q - 1'b1;
    end else begin
      pulse_out_q <= 1'b0;
    end
  end

  // dilution passed through
  // a report still leaving at the next tick skips that tick's report
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rpt_q <= '0;
      shift_q <= '1;
      bits_q <= '0;
      bytes_q <= '0;
      baud_q <= '0;
      busy_tx_q <= 1'b0;
      tx_q <= 1'b1;
    end else if (tick && !busy_tx_q) begin
      rpt_q <= {`GFS_RPT_START, 1'b0, issue_d, unc_d, !issue_d, 4'(used_d),
                precision_dilution_in};
      bytes_q <= `GFS_RPT_BYTES;
      bits_q <= '0;
      baud_q <= '0;
      busy_tx_q <= 1'b1;
    end else if (busy_tx_q) begin
      if (baud_q != '0) begin
        baud_q <= baud_q - 1'b1;
      end else if (bits_q != '0) begin
        tx_q <= shift_q[0];
        shift_q <= {1'b1, shift_q[9:1]};
        bits_q <= bits_q - 1'b1;
        baud_q <= DW'(BAUD_DIV - 1);
      end else if (bytes_q != '0) begin
        shift_q <= {1'b1, rpt_q[23:16], 1'b0};
        rpt_q <= {rpt_q[15:0], 8'h00};
        bytes_q <= bytes_q - 1'b1;
        bits_q <= `GFS_FRAME_BITS;
      end else begin
        busy_tx_q <= 1'b0;
      end
    end
  end

  assign tx_out = tx_q;
  assign fix_status_out = fix_out_q;
  assign pos_pulse_out = pulse_out_q;
  assign nav_solution_out = nav_q;
  assign cand_ack_out = ack_q;

  property p_none_low;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (trk_cnt == '0) |=> !fix_status_out && !pos_pulse_out ##0 $past(!issue_d);
  endproperty
  a_none_low: assert property (p_none_low) else $error("status high with nothing tracked");

  property p_blink_edge;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (fix_q == FIX_SEARCH && $past(fix_q) == FIX_SEARCH && $changed(fix_status_out))
      |-> $past(blink_q) == BW'(BLINK_CYC - 1);
  endproperty
  a_blink_edge: assert property (p_blink_edge) else $error("blink toggled off count");

  property p_valid_high;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (fix_q == FIX_VALID) |-> fix_status_out && $past(nav_solution_out.fix);
  endproperty
  a_valid_high: assert property (p_valid_high) else $error("valid fix not high");

  property p_fix_four;
    @(posedge mclk_in) disable iff (!rst_b_in)
    nav_solution_out.fix |-> nav_solution_out.used >= 4'(`GFS_MIN_SATS);
  endproperty
  a_fix_four: assert property (p_fix_four) else $error("fix on too few satellites");

  property p_pulse_cause;
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(pos_pulse_out) |-> $past(tick) && $past(issue_d) && nav_solution_out.fix;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without issued fix");

  property p_uncertain;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (tick && !gate_q && all_cnt >= CW'(`GFS_MIN_SATS) && masked_cnt < CW'(`GFS_MIN_SATS))
      |=> nav_solution_out.uncertain && nav_solution_out.fix && gate_q;
  endproperty
  a_uncertain: assert property (p_uncertain) else $error("low-satellite fix not flagged");

  property p_gated_empty;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (tick && gate_q && masked_cnt < CW'(`GFS_MIN_SATS)) |=> nav_solution_out.empty;
  endproperty
  a_gated_empty: assert property (p_gated_empty) else $error("gated report not empty");

  property p_bit_steady;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (busy_tx_q && baud_q != '0) |=> $stable(tx_out);
  endproperty
  a_bit_steady: assert property (p_bit_steady) else $error("serial bit changed mid bit");

  property p_blink_restart;
    @(posedge mclk_in) disable iff (!rst_b_in)
    (fix_d != fix_q) |=> blink_q == '0;
  endproperty
  a_blink_restart: assert property (p_blink_restart) else $error("blink count not restarted");

endmodule // gfs_fix_status

// ### testbench/gfs_host_model.sv
`timescale 1ns/100ps

// host computer watching the status pins and the report line
module gfs_host_model #(
  parameter int BAUD_DIV = 4
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // pins from the device
  input wire logic tx_in,
  input wire logic fix_status_in,
  input wire logic pos_pulse_in,
  // pin to the device
  output logic rxd_out
);
  logic [7:0] rx_q[$];
  int hi_len = 0;
  int lo_len = 0;
  int pulse_len = 0;
  int run = 0;
  int prun = 0;
  int seed = 10;
  logic last = 1'b0;

  // junk bytes on the unused line
  initial rxd_out = 1'b1;
  always @(posedge mclk_in) rxd_out <= 1'($random(seed));

  // level run lengths, last full run kept
  always @(posedge mclk_in) begin
    if (fix_status_in !== last) begin
      if (last) hi_len <= run;
      else lo_len <= run;
      run <= 1;
    end else run <= run + 1;
    last <= fix_status_in;
    prun <= pos_pulse_in ? prun + 1 : 0;
    if (!pos_pulse_in && prun > 0) pulse_len <= prun;
  end

  // report decoder, samples mid-bit, lsb first
  initial begin
    logic [7:0] b;
    forever begin
      @(posedge mclk_in);
      if (tx_in === 1'b0) begin
        repeat (BAUD_DIV / 2) @(posedge mclk_in);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD_DIV) @(posedge mclk_in);
          b[i] = tx_in;
        end
        repeat (BAUD_DIV) @(posedge mclk_in);
        rx_q.push_back(b);
      end
    end
  end
endmodule // gfs_host_model

// ### testbench/tb_gfs_fix_status.sv
`timescale 1ns/100ps

module tb_gfs_fix_status;
  import gfs_pkg::*;
  localparam int BLINK = 20;
  localparam int EPOCH = 200;
  localparam int PULSE = 5;
  logic mclk_in = 1'b0;
  logic rst_b_in = 1'b0;
  gfs_meas_s meas [15];
  gfs_cand_s cand = '0;
  logic [7:0] pd = 8'h00;
  logic rxd, tx_out, fix_status_out, pos_pulse_out, cand_ack_out;
  gfs_nav_s nav;
  int fails = 0;
  int samples_checked = 0;
  int seed = 10;
  int cyc = 0;
  int ec = 0;
  int trk [15] = '{default: 0};
  logic gate = 1'b0;
  logic chk_n = 1'b0;
  logic e_fix, e_unc, e_emp, e_any, e_gon;
  logic [3:0] e_used;
  logic [7:0] pd_exp;

  // clock
  always #25 mclk_in = ~mclk_in;

  // short counts keep the run brief
  gfs_fix_status #(.BLINK_CYC(BLINK), .EPOCH_CYC(EPOCH), .PULSE_CYC(PULSE),
    .SEEK_CYC(100), .FADE_CYC(60), .BAUD_DIV(4)) u_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .meas_in(meas), .cand_in(cand),
    .precision_dilution_in(pd), .rxd_in(rxd), .tx_out(tx_out),
    .fix_status_out(fix_status_out), .pos_pulse_out(pos_pulse_out),
    .nav_solution_out(nav), .cand_ack_out(cand_ack_out));

  gfs_host_model #(.BAUD_DIV(4)) u_host (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .tx_in(tx_out),
    .fix_status_in(fix_status_out), .pos_pulse_in(pos_pulse_out), .rxd_out(rxd));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // returns just after an epoch tick
  task automatic wait_epoch();
    do @(posedge mclk_in); while (ec != 2);
  endtask

  task automatic put(input int c, input logic [7:0] cn, input logic signed [7:0] el);
    meas[c] <= '{cn, el};
  endtask

  // offer held until acknowledged or given up after ten edges
  task automatic offer(input logic [5:0] prn, input logic ok);
    int n;
    n = 0;
    @(posedge mclk_in);
    cand <= '{1'b1, prn};
    do begin
      @(posedge mclk_in);
      n++;
    end while (cand_ack_out !== 1'b1 && n < 10);
    cand <= '{1'b0, prn};
    chk(n, ok ? 2 : 10);
  endtask

  task automatic chk_rst();
    chk({tx_out, fix_status_out, pos_pulse_out, cand_ack_out, nav}, 11'h400);
  endtask

  // hang guard, about three times the expected run
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      test_done();
    end
  end

  // epoch mirror and expected solution; rxd is never consulted
  always @(posedge mclk_in) begin
    int n_up, n_any, n_tr;
    pd <= 8'($random(seed));
    if (!rst_b_in) begin
      ec <= 0;
      gate = 1'b0;
      chk_n <= 1'b0;
    end else begin
      if (chk_n) begin
        chk(pos_pulse_out, e_fix);
        chk(nav.fix, e_fix);
        if (e_fix) chk({nav.uncertain, nav.used}, {e_unc, e_used});
        if (e_gon && e_any) chk(nav.empty, e_emp);
      end
      chk_n <= (ec == EPOCH - 1);
      if (ec == EPOCH - 1) begin
        chk(pos_pulse_out, 1'b0);
        n_up = 0;
        n_any = 0;
        n_tr = 0;
        for (int c = 0; c < 15; c++) begin
          n_tr += trk[c];
          if (trk[c] != 0 && meas[c].cn0 >= 30) begin
            n_any++;
            n_up += (meas[c].elev >= 3);
          end
        end
        e_gon = gate;
        e_any = (n_tr > 0);
        e_emp = gate && n_up < 4;
        e_fix = e_any && (gate ? n_up >= 4 : n_any >= 4);
        e_unc = !gate && n_up < 4;
        e_used = 4'(gate ? n_up : n_any);
        if (e_fix) gate = 1'b1;
        pd_exp = pd;
      end
      ec <= (ec == EPOCH - 1) ? 0 : ec + 1;
    end
  end

  // main sequence
  initial begin
    for (int c = 0; c < 15; c++) meas[c] = '{8'd37, 8'sd0};
    repeat (3) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    chk_rst();
    $display("test reset done");
    // all channels seek at 37, never lock, time out
    for (int p = 1; p <= 15; p++) offer(6'(p), 1'b1);
    offer(6'd16, 1'b0);
    repeat (120) @(posedge mclk_in);
    chk(fix_status_out, 1'b0);
    offer(6'd17, 1'b1);
    $display("test channels done");
    // four strong satellites below the mask
    wait_epoch();
    for (int c = 0; c < 15; c++) put(c, c < 4 ? 8'd40 : 8'd0, -8'sd5);
    for (int p = 1; p <= 4; p++) begin
      offer(6'(p), 1'b1);
      trk[p - 1] = 1;
    end
    // a repeat offer of a held satellite is consumed without a new channel
    offer(6'd2, 1'b1);
    wait_epoch();
    repeat (5) @(posedge mclk_in);
    chk(fix_status_out, 1'b1);
    repeat (3) wait_epoch();
    chk(u_host.hi_len, BLINK);
    chk(u_host.lo_len, BLINK);
    $display("test low satellites done");
    // raised above the mask
    for (int c = 0; c < 4; c++) put(c, 8'd40, 8'sd10);
    wait_epoch();
    repeat (150) @(posedge mclk_in);
    chk(fix_status_out, 1'b1);
    chk(u_host.pulse_len, PULSE);
    chk({u_host.rx_q[$-2], u_host.rx_q[$-1], u_host.rx_q[$]}, {16'h2444, pd_exp});
    $display("test fix done");
    // weak but tracked satellite left out
    wait_epoch();
    put(3, 8'd28, 8'sd10);
    wait_epoch();
    // short fade on another channel
    put(3, 8'd40, 8'sd10);
    put(2, 8'd20, 8'sd10);
    repeat (20) @(posedge mclk_in);
    put(2, 8'd40, 8'sd10);
    wait_epoch();
    $display("test fade done");
    // total loss
    for (int c = 0; c < 15; c++) put(c, 8'd0, 8'sd10);
    trk = '{default: 0};
    repeat (5) @(posedge mclk_in);
    chk(fix_status_out, 1'b0);
    wait_epoch();
    // single-edge reset in mid-run
    rst_b_in <= 1'b0;
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    chk_rst();
    $display("test loss and reset done");
    test_done();
  end
endmodule // tb_gfs_fix_status
